// file: iawc_pkg.sv
package iawc_pkg;
    // source count: index 0 = software interrupt, 1 = pin, then flag numbers 2..23
    localparam int NUM_SRC = 24;
    // register byte addresses on the bus
    localparam logic [3:0] ADDR_STATUS_LOW = 4'h0;
    localparam logic [3:0] ADDR_STATUS_MID = 4'h4;
    localparam logic [3:0] ADDR_STATUS_HIGH = 4'h8;
    localparam logic [3:0] ADDR_BREAK_FLAG_CTRL = 4'hC;
    // break flag control register fields
    localparam int BFC_CLEAR_EN_BIT = 7;
    localparam logic [7:0] BFC_RESET = 8'h00;
    // break status register field
    localparam int BSR_STOP_WAIT_BIT = 1;
    // vector addresses (first byte of two)
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_SWI = 16'hFFFC;
    localparam logic [15:0] VEC_TOP = 16'hFFFE;
    // flag positions that exist (pin 1, timer 3..7, serial 9..11, spi 12..13, kbd 14, adc 15)
    localparam logic [23:0] FLAG_IMPL = 24'h00FEFA;
    // cpu sequencing states
    typedef enum logic [2:0] {
        IAWC_RUN,
        IAWC_STACK,
        IAWC_VECTOR,
        IAWC_WAIT,
        IAWC_BREAK
    } iawc_state_e;
endpackage

// file: iawc_prio_if.sv
`timescale 1ns/1ns
`default_nettype none
// carries the pending set to the priority encoder and the result back
interface iawc_prio_if;
    logic [23:0] pend; // enabled pending flags
    logic hit; // any pending
    logic [4:0] idx; // winning flag number
    logic [15:0] vec; // vector address for winner
    modport arb (output pend, input hit, idx, vec);
    modport enc (input pend, output hit, idx, vec);
endinterface
`default_nettype wire

// file: iawc_prio_enc.sv
`timescale 1ns/1ns
`default_nettype none
// fixed priority encoder: lowest flag number wins
module iawc_prio_enc
    import iawc_pkg::*;
(
    iawc_prio_if.enc p
);
    // vector for flag n is top minus two per flag, minus two more for the reset slot
    function automatic logic [15:0] vec_of(input logic [4:0] n);
        vec_of = VEC_TOP - {10'h000, n, 1'b0} - 16'h0002;
    endfunction

    // scan from lowest to highest priority so the highest wins
    always_comb begin
        p.hit = 1'b0;
        p.idx = 5'h00;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (p.pend[i]) begin
                p.hit = 1'b1;
                p.idx = 5'(i);
            end
        end
        p.vec = vec_of(p.idx);
    end
endmodule
`default_nettype wire

// file: iawc_top.sv
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - hardware interrupts wait for instruction end
// - service only if mask clear and enabled
// - highest fixed priority pending at latch time serviced first
// - pending after return serviced before program
// - stacking never pushes high index register
// - software interrupt ignores the global mask
// - swi stacks pc, hardware stacks pc-1
// - fixed priority vectors, two bytes each
// - each maskable source drives own flag
// - global mask gates all but swi
// - flag reads 1 while request present
// - resets bypass arbitration, highest priority
// - break request forces software interrupt vector
// - break blocks flag clears unless enabled
// - flag cleared in break stays cleared
// - two-step clears stay protected through break
// - low-power instructions clear the global mask
// - wait gates cpu clocks, peripherals run
// - wait wakes on enabled interrupt, stacks next
// - reset or break exits wait, sets bit; here break exits wait only with emu_mode_i set
// - watchdog runs in wait unless disabled
// - latched interrupt holds until serviced or masked
// - entry stacks registers and sets mask
module iawc_top
    import iawc_pkg::*;
#(
    parameter int SRC_W = 24
) (
    input wire logic clk_i, // bus clock
    input wire logic rst_i, // any system reset
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // cpu core side
    input wire logic instr_done_i, // pulse: current instruction completed
    input wire logic swi_exec_i, // pulse: software interrupt instruction executed
    input wire logic wait_exec_i, // pulse: wait instruction executed
    input wire logic stop_exec_i, // pulse: stop instruction executed
    input wire logic rti_done_i, // pulse: return from interrupt completed
    input wire logic ccr_mask_i, // global interrupt mask as held by cpu
    input wire logic [15:0] pc_i, // current program counter
    input wire logic stack_done_i, // pulse: cpu finished stacking
    // peripheral side
    input wire logic [SRC_W-1:0] irq_req_i, // request levels per flag number
    input wire logic [SRC_W-1:0] irq_en_i, // source enables per flag number
    input wire logic brk_req_i, // break module request
    input wire logic emu_mode_i, // emulation mode allows break to exit wait
    input wire logic watchdog_disable_bit_i, // configuration bit
    // outputs to cpu
    output logic int_take_o, // pulse: begin interrupt entry
    output logic [15:0] vector_o, // vector address to fetch
    output logic [15:0] ret_addr_o, // return address to stack
    output logic push_high_index_o, // always low: high index not stacked
    output logic set_mask_o, // pulse: set global mask
    output logic clr_mask_o, // pulse: clear global mask
    output logic cpu_clk_en_o, // cpu clock gate
    output logic periph_clk_en_o, // peripheral clock gate
    output logic watchdog_run_o, // watchdog counting enable
    output logic in_break_o, // break state
    output logic flag_clear_allow_o, // peripherals may clear status flags
    output logic break_from_stop_wait_bit_o // break status bit
);
    iawc_state_e state; // sequencing state
    logic [7:0] break_flag_control_reg; // software break clear control
    logic [23:0] latched_req; // request snapshot, flags 0..23
    logic [23:0] pend_mask; // enabled and unmasked pending
    logic have_latch; // an interrupt is latched for service
    logic [4:0] latch_idx; // latched flag number
    logic [15:0] latch_vec; // latched vector
    logic rd_hit; // bus read/write this cycle
    logic [31:0] next_dat; // read mux
    logic [23:0] req_sync1; // request synchronizer stage 1
    logic [23:0] req_sync2; // stage 2
    logic [23:0] req_sync3; // stage 3
    logic [23:0] req_stable; // debounced request levels
    logic brk_s1, brk_s2, brk_s3, brk_lvl; // break synchronizer
    logic brk_active; // in break now, or break begins on this edge

    iawc_prio_if pif();

    iawc_prio_enc u_enc (
        .p(pif.enc)
    );

    // request inputs come from other logic blocks, synchronise them anyway
    // three stages keep a late-changing level from reaching the arbiter half-settled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_sync1 <= 24'h000000;
            req_sync2 <= 24'h000000;
            req_sync3 <= 24'h000000;
        end else begin
            req_sync1 <= irq_req_i[23:0];
            req_sync2 <= req_sync1;
            req_sync3 <= req_sync2;
        end
    end

    // accept a level change only when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_stable <= 24'h000000;
        end else begin
            for (int i = 0; i < 24; i++) begin
                if (req_sync2[i] == req_sync3[i]) begin
                    req_stable[i] <= req_sync3[i];
                end
            end
        end
    end

    // break request synchronizer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            brk_s1 <= 1'b0;
            brk_s2 <= 1'b0;
            brk_s3 <= 1'b0;
            brk_lvl <= 1'b0;
        end else begin
            brk_s1 <= brk_req_i;
            brk_s2 <= brk_s1;
            brk_s3 <= brk_s2;
            if (brk_s2 == brk_s3) begin
                brk_lvl <= brk_s3;
            end
        end
    end

    // flags exist only at implemented positions
    // absent positions are masked here so neither the status bytes nor the arbiter see them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched_req <= 24'h000000;
        end else begin
            latched_req <= req_stable & FLAG_IMPL;
        end
    end

    // enabled sources gated by the global mask; swi is never here
    always_comb begin
        pend_mask = (ccr_mask_i) ? 24'h000000 : (latched_req & irq_en_i[23:0]);
    end
    assign pif.pend = pend_mask;

    // bus decode: single-cycle ack, dropped the cycle after
    assign rd_hit = cyc_i & stb_i & ~ack_o;

    // ack generation
    // a request still held after its ack is answered again, so a master must drop cyc
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= rd_hit;
        end
    end

    // read mux; status registers are read-only, unused bits zero
    // low byte: pin flag at bit 2, timer flags 3..6 at bits 4..7; bits 0, 1 and 3 read zero
    // mid byte: flags 7..14 in order from bit 0
    // high byte: flags 15..22 in order from bit 0; only flag 15 exists here
    always_comb begin
        next_dat = 32'h00000000;
        unique case (adr_i)
            // writes never reach these three; a read only mirrors the snapshot
            ADDR_STATUS_LOW: next_dat = {24'h000000, latched_req[6:3], 1'b0, latched_req[1], 2'b00};
            ADDR_STATUS_MID: next_dat = {24'h000000, latched_req[14:7]};
            ADDR_STATUS_HIGH: next_dat = {24'h000000, latched_req[22:15]};
            // the only control byte that software may change
            ADDR_BREAK_FLAG_CTRL: next_dat = {24'h000000, break_flag_control_reg};
            default: next_dat = 32'h00000000; // unmapped reads zero
        endcase
    end

    // read data register
    // holds between reads so a slow master can still pick it up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (rd_hit && !we_i) begin
            dat_o <= next_dat;
        end
    end

    // only the break control register is writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            break_flag_control_reg <= BFC_RESET;
        end else if (rd_hit && we_i && sel_i[0] && adr_i == ADDR_BREAK_FLAG_CTRL) begin
            break_flag_control_reg <= {dat_i[7], 7'h00};
        end
    end

    // sequencing: reset puts all in run; reset vector is outside arbitration
    // in run the order is break, software interrupt, low-power entry, then hardware entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= IAWC_RUN;
            have_latch <= 1'b0;
            latch_idx <= 5'h00;
            latch_vec <= VEC_RESET;
            int_take_o <= 1'b0;
            vector_o <= VEC_RESET;
            ret_addr_o <= 16'h0000;
            set_mask_o <= 1'b0;
            clr_mask_o <= 1'b0;
            in_break_o <= 1'b0;
        end else begin
            int_take_o <= 1'b0;
            set_mask_o <= 1'b0;
            clr_mask_o <= 1'b0;
            // drop a latch only if the mask was set back on by cpu
            if (have_latch && ccr_mask_i && state == IAWC_RUN) begin
                have_latch <= 1'b0;
            end
            unique case (state)
                IAWC_RUN: begin
                    if (brk_lvl) begin
                        // break forces swi vector
                        state <= IAWC_BREAK;
                        in_break_o <= 1'b1;
                        vector_o <= VEC_SWI;
                        ret_addr_o <= pc_i;
                        int_take_o <= 1'b1;
                        set_mask_o <= 1'b1;
                    end else if (swi_exec_i) begin
                        // software interrupt regardless of mask
                        state <= IAWC_STACK;
                        vector_o <= VEC_SWI;
                        ret_addr_o <= pc_i;
                        int_take_o <= 1'b1;
                        set_mask_o <= 1'b1;
                    end else if (wait_exec_i || stop_exec_i) begin
                        clr_mask_o <= 1'b1;
                        state <= wait_exec_i ? IAWC_WAIT : IAWC_RUN;
                    end else if ((instr_done_i || rti_done_i) && ((have_latch && !ccr_mask_i) || pif.hit)) begin
                        // only at instruction boundary, incl. after return; a latch that
                        // meets a freshly set mask must not slip through in that cycle
                        state <= IAWC_STACK;
                        vector_o <= have_latch ? latch_vec : pif.vec;
                        ret_addr_o <= pc_i - 16'h0001;
                        int_take_o <= 1'b1;
                        set_mask_o <= 1'b1;
                        have_latch <= 1'b0;
                    end else if (pif.hit && !have_latch) begin
                        // latch winner so later higher requests cannot displace it
                        have_latch <= 1'b1;
                        latch_idx <= pif.idx;
                        latch_vec <= pif.vec;
                    end
                end
                IAWC_WAIT: begin
                    // cpu clocks stay off here until an enabled source, or a break with emu_mode_i set, arrives
                    if (brk_lvl && emu_mode_i) begin
                        state <= IAWC_BREAK;
                        in_break_o <= 1'b1;
                        vector_o <= VEC_SWI;
                        ret_addr_o <= pc_i;
                        int_take_o <= 1'b1;
                        set_mask_o <= 1'b1;
                    end else if (pif.hit) begin
                        // wake and stack next cycle
                        state <= IAWC_STACK;
                        vector_o <= pif.vec;
                        ret_addr_o <= pc_i - 16'h0001;
                        int_take_o <= 1'b1;
                        set_mask_o <= 1'b1;
                    end
                end
                IAWC_STACK: begin
                    // hold until the core reports its registers pushed
                    if (stack_done_i) begin
                        state <= IAWC_VECTOR;
                    end
                end
                IAWC_VECTOR: begin
                    // one cycle for the vector fetch before normal running
                    state <= IAWC_RUN;
                end
                IAWC_BREAK: begin
                    // leave once the break request has gone away
                    if (!brk_lvl) begin
                        state <= IAWC_RUN;
                        in_break_o <= 1'b0;
                    end
                end
                default: state <= IAWC_RUN;
            endcase
        end
    end

    // break during wait with emu_mode_i set sets the status bit; cleared by reset only
    // the bit survives leaving break so software can see why wait ended
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            break_from_stop_wait_bit_o <= 1'b0;
        end else if (state == IAWC_WAIT && brk_lvl && emu_mode_i) begin
            break_from_stop_wait_bit_o <= 1'b1;
        end
    end

    // break is active now, or begins on this edge from run, or from wait under emulation
    always_comb begin
        brk_active = in_break_o || (brk_lvl && (state == IAWC_RUN || (state == IAWC_WAIT && emu_mode_i)));
    end

    // flag clearing permission: blocked in break unless enabled; clears done then persist in
    // the peripheral, and a pending two-step clear stays blocked until break ends
    // permission drops on the edge that break begins, so no clear slips into its first cycle;
    // it returns one cycle after break ends, which only delays a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_clear_allow_o <= 1'b1;
        end else begin
            flag_clear_allow_o <= !brk_active || break_flag_control_reg[BFC_CLEAR_EN_BIT];
        end
    end

    // clock gating and watchdog
    // the cpu clock stops the cycle after wait begins and runs again one cycle after wake-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_clk_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
            watchdog_run_o <= 1'b1;
            push_high_index_o <= 1'b0;
        end else begin
            cpu_clk_en_o <= !(state == IAWC_WAIT);
            periph_clk_en_o <= 1'b1;
            watchdog_run_o <= !watchdog_disable_bit_i;
            push_high_index_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: iawc_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// cpu stand-in: ends stacking a while after each interrupt entry
module iawc_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i, // stretch stacking like a slow core
    input wire logic int_take_i,
    output logic stack_done_o
);
    logic [2:0] cnt; // cycles left until stacking ends
    // pushes registers, never the high index, then reports done
    always_ff @(posedge clk_i) begin
        stack_done_o <= 1'b0;
        if (rst_i) begin
            cnt <= 3'h0;
        end else if (int_take_i) begin
            cnt <= slow_i ? 3'h5 : 3'h1;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            stack_done_o <= (cnt == 3'h1);
        end
    end
endmodule
`default_nettype wire

// file: iawc_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
// watches the top ports for sequencing slips
module iawc_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ack_o,
    input wire logic instr_done_i,
    input wire logic swi_exec_i,
    input wire logic wait_exec_i,
    input wire logic stop_exec_i,
    input wire logic ccr_mask_i,
    input wire logic [15:0] pc_i,
    input wire logic brk_req_i,
    input wire logic watchdog_disable_bit_i,
    input wire logic int_take_o,
    input wire logic [15:0] vector_o,
    input wire logic [15:0] ret_addr_o,
    input wire logic push_high_index_o,
    input wire logic set_mask_o,
    input wire logic clr_mask_o,
    input wire logic periph_clk_en_o,
    input wire logic watchdog_run_o,
    input wire logic in_break_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // entry step: take pulse with mask set
    sequence s_entry;
        int_take_o && set_mask_o;
    endsequence
    // hardware entry, not software nor break
    sequence s_hw_entry;
        int_take_o && !$past(swi_exec_i) && !in_break_o;
    endsequence
    a_high_index_low: assert property (push_high_index_o == 1'b0) else $error("high index pushed");
    a_periph_clk_on: assert property (periph_clk_en_o == 1'b1) else $error("peripheral clock off");
    a_watchdog_run: assert property (!$past(rst_i) |-> watchdog_run_o == !$past(watchdog_disable_bit_i))
        else $error("watchdog enable wrong");
    a_swi_entry: assert property (swi_exec_i |=> s_entry ##0 (vector_o == 16'hFFFC && ret_addr_o == $past(pc_i)))
        else $error("software entry wrong");
    a_mask_blocks: assert property (instr_done_i && ccr_mask_i && !swi_exec_i && !brk_req_i |=> !int_take_o)
        else $error("masked interrupt taken");
    a_hw_ret_addr: assert property (s_hw_entry |-> ret_addr_o == $past(pc_i) - 16'h0001
        && vector_o <= 16'hFFFA && vector_o >= 16'hFFDE) else $error("hardware entry wrong");
    a_entry_masks: assert property (int_take_o |-> s_entry) else $error("entry without mask");
    a_lowpwr_unmask: assert property (wait_exec_i || stop_exec_i |=> clr_mask_o)
        else $error("mask not cleared");
    a_break_vector: assert property ($rose(in_break_o) |-> vector_o == 16'hFFFC)
        else $error("break vector wrong");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held");
endmodule
bind iawc_top iawc_chk u_chk (.*);
`default_nettype wire

// file: iawc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
module iawc_top_test;
    import iawc_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, idone = 0, software_interrupt_instr = 0, wt = 0, stp = 0, return_from_interrupt = 0;
    logic mask = 1, brk = 0, emu = 0, wdd = 0, slow = 0;
    logic [3:0] adr = 4'h0; // bus address
    logic [31:0] wdat = 32'h0, q; // write data, last read data
    logic [15:0] pc = 16'h1234; // held program counter
    logic [23:0] req = 24'h0, en = 24'h0; // request and enable levels
    int miscompares = 0, cmp_count = 0, cycles = 0;
    wire logic [31:0] dat;
    wire logic ack, sdone, take, cclk, wdrun, inbrk, allow, bsw;
    wire logic [15:0] vec, ret;
    iawc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(wdat), .dat_o(dat), .ack_o(ack), .instr_done_i(idone), .swi_exec_i(software_interrupt_instr), .wait_exec_i(wt),
        .stop_exec_i(stp), .rti_done_i(return_from_interrupt), .ccr_mask_i(mask), .pc_i(pc), .stack_done_i(sdone),
        .irq_req_i(req), .irq_en_i(en), .brk_req_i(brk), .emu_mode_i(emu), .watchdog_disable_bit_i(wdd),
        .int_take_o(take), .vector_o(vec), .ret_addr_o(ret), .push_high_index_o(), .set_mask_o(),
        .clr_mask_o(), .cpu_clk_en_o(cclk), .periph_clk_en_o(), .watchdog_run_o(wdrun), .in_break_o(inbrk),
        .flag_clear_allow_o(allow), .break_from_stop_wait_bit_o(bsw));
    iawc_cpu_model u_cpu (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .int_take_i(take), .stack_done_o(sdone));
    always #5 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        q = dat;
        cyc <= 1'b0; stb <= 1'b0;
        chk(n < 20, 1'b1);
    endtask
    // waits for entry then judges vector and return address
    task automatic wait_take(input logic [15:0] v, input logic [15:0] r);
        int n;
        for (n = 0; n < 30 && take !== 1'b1; n++) @(negedge clk_i);
        chk(take, 1'b1);
        chk(vec, v);
        chk(ret, r);
        tick(8);
    endtask
    task automatic t_status();
        req <= 24'hFFFFFF; tick(8);
        wb(0, ADDR_STATUS_LOW, 0); chk(q, 32'hF4);
        wb(0, ADDR_STATUS_MID, 0); chk(q, 32'hFD);
        wb(0, ADDR_STATUS_HIGH, 0); chk(q, 32'h01);
        wb(1, ADDR_STATUS_LOW, 32'hFF); wb(0, ADDR_STATUS_LOW, 0); chk(q, 32'hF4);
        wb(0, 4'h2, 0); chk(q, 32'h0);
        req <= 24'h0; tick(8);
        wb(0, ADDR_STATUS_LOW, 0); chk(q, 32'h00);
    endtask
    task automatic t_prio();
        en <= 24'hFFFFFF; mask <= 1'b0; req <= 24'h1020; tick(8);
        repeat (4) @(negedge clk_i) chk(take, 1'b0);
        tick(1); req <= 24'h1022; tick(6); idone <= 1'b1; tick(1); idone <= 1'b0;
        wait_take(16'hFFF2, 16'h1233);
        mask <= 1'b1; req <= 24'h1000; tick(6);
        mask <= 1'b0; return_from_interrupt <= 1'b1; tick(1); return_from_interrupt <= 1'b0;
        wait_take(16'hFFE4, 16'h1233);
        mask <= 1'b1; tick(4); idone <= 1'b1; tick(1); idone <= 1'b0;
        repeat (4) @(negedge clk_i) chk(take, 1'b0);
        tick(1); mask <= 1'b0; en <= 24'h0; idone <= 1'b1; tick(1); idone <= 1'b0;
        repeat (4) @(negedge clk_i) chk(take, 1'b0);
        tick(1); en <= 24'hFFFFFF; req <= 24'h0; tick(8);
    endtask
    task automatic t_swi();
        mask <= 1'b1; slow <= 1'b1; software_interrupt_instr <= 1'b1; tick(1); software_interrupt_instr <= 1'b0;
        wait_take(VEC_SWI, 16'h1234);
    endtask
    task automatic t_wait();
        wt <= 1'b1; tick(1); wt <= 1'b0; tick(3);
        chk(cclk, 1'b0);
        chk(wdrun, 1'b1);
        mask <= 1'b0; req <= 24'h8;
        wait_take(16'hFFF6, 16'h1233);
        req <= 24'h0; wdd <= 1'b1; tick(3);
        chk(wdrun, 1'b0);
        wdd <= 1'b0;
    endtask
    task automatic t_break();
        wb(1, ADDR_BREAK_FLAG_CTRL, 32'h80); wb(0, ADDR_BREAK_FLAG_CTRL, 0); chk(q, 32'h80);
        wb(1, ADDR_BREAK_FLAG_CTRL, 32'h0);
        tick(1); wt <= 1'b1; tick(1); wt <= 1'b0; tick(3);
        emu <= 1'b1; brk <= 1'b1;
        for (int n = 0; n < 20 && inbrk !== 1'b1; n++) @(negedge clk_i);
        chk(vec, VEC_SWI);
        chk(bsw, 1'b1);
        chk(allow, 1'b0);
        wb(1, ADDR_BREAK_FLAG_CTRL, 32'h80); tick(2);
        chk(allow, 1'b1);
        brk <= 1'b0; tick(10);
        chk(inbrk, 1'b0);
        chk(allow, 1'b1);
        wb(1, ADDR_BREAK_FLAG_CTRL, 32'h0); tick(1);
        chk(allow, 1'b1);
        stp <= 1'b1; tick(1); stp <= 1'b0; tick(3);
    endtask
    initial begin
        tick(16);
        rst_i <= 1'b0;
        chk(vec, VEC_RESET);
        t_status();
        t_prio();
        t_swi();
        t_wait();
        t_break();
        stop_test();
    end
endmodule
`default_nettype wire
